/* File: shared/imac_defines.svh */
// Register indices, field positions, reset values and sizes for the indirect memory access block.
`ifndef IMAC_DEFINES_SVH
`define IMAC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IMAC_IDX_ADDR_BUF 6'h0c
`define IMAC_IDX_WR_DATA 6'h0d
`define IMAC_IDX_RD_DATA 6'h0e
`define IMAC_IDX_INT_STAT 6'h10
`define IMAC_IDX_INT_MASK 6'h11
`define IMAC_IDX_RATE 6'h12

// ----------------------------------------------------------------
// Address buffer fields
// ----------------------------------------------------------------
`define IMAC_AB_DONE 14
`define IMAC_AB_RSEL 13
`define IMAC_AB_WSEL 12
`define IMAC_AB_CH_HI 11
`define IMAC_AB_CH_LO 5
`define IMAC_AB_ST_HI 4
`define IMAC_AB_ST_LO 0

// ----------------------------------------------------------------
// Backplane connection word fields
// ----------------------------------------------------------------
`define IMAC_CW_CONST 13
`define IMAC_CW_MSG 12
`define IMAC_CW_DIR 11
`define IMAC_CW_SST_HI 10
`define IMAC_CW_SST_LO 7
`define IMAC_CW_SCH_HI 6
`define IMAC_CW_SCH_LO 0

// ----------------------------------------------------------------
// Interrupt bits, reset values, limits
// ----------------------------------------------------------------
`define IMAC_INT_DONE 0
`define IMAC_INT_RANGE 1
`define IMAC_RST_ADDR_BUF 16'h0000
`define IMAC_RST_WR_DATA 16'h0000
`define IMAC_RST_MASK 2'h0
`define IMAC_CM_DEPTH 128
`define IMAC_MAX_ST_2M 4'hf
`define IMAC_MAX_ST_8M 4'h3
`define IMAC_MAX_ST_SUB 4'hc

`endif

/* File: shared/imac_pkg.sv */
// Types shared by the indirect memory access block.
package imac_pkg;

    typedef enum logic [1:0] {IMAC_RATE_2M, IMAC_RATE_8M, IMAC_RATE_SUB} imac_rate_t;

    typedef enum logic [0:0] {IMAC_X_IDLE, IMAC_X_BUSY} imac_xfer_t;

endpackage : imac_pkg

/* File: verilog/imac_top.sv */
// Indirect access to the backplane connection memory and the per-channel output datapath.
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "imac_defines.svh"

module imac_top
    import imac_pkg::*;
(
    input wire logic pclk, // Bus and switch clock.
    input wire logic presetn, // Asynchronous reset.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic [6:0] slot_index, // Output channel now being built.
    input wire logic [7:0] local_data, // Local data memory read data.
    output logic [3:0] local_stream, // Local data memory stream address.
    output logic [6:0] local_channel, // Local data memory channel address.
    output logic [7:0] backplane_serial_line_data, // Byte for the backplane output.
    output logic backplane_serial_line_oe, // Backplane driver enable.
    output logic const_delay, // Constant throughput delay for the slot.
    output logic irq // Level interrupt.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] abuf;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [1:0] sw_sel;
        imac_xfer_t xst;
        logic xrd;
        logic [1:0] int_stat;
        logic [1:0] int_mask;
        imac_rate_t rate;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [`IMAC_CM_DEPTH-1:0][15:0] cmem;
        logic p1_msg;
        logic p1_oe;
        logic p1_cd;
        logic [7:0] p1_byte;
        logic [7:0] out_data;
        logic out_oe;
        logic out_cd;
        logic [3:0] lst;
        logic [6:0] lch;
        logic irq;
    } imac_state_t;

    imac_state_t s_q;
    imac_state_t s_d;

    logic [5:0] reg_idx;
    logic acc_ok;
    logic wr_now;
    logic [15:0] cur_word;
    logic [3:0] max_st;
    logic [3:0] src_st;
    logic [6:0] src_ch;
    logic range_err;
    logic rise_rd;
    logic rise_wr;
    logic hw_done;

    assign reg_idx = paddr[7:2];
    assign cur_word = s_q.cmem[slot_index];
    assign wr_now = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    assign src_st = cur_word[`IMAC_CW_SST_HI:`IMAC_CW_SST_LO];

    always_comb
    begin
        case (reg_idx)
            `IMAC_IDX_ADDR_BUF, `IMAC_IDX_WR_DATA, `IMAC_IDX_RD_DATA,
            `IMAC_IDX_INT_STAT, `IMAC_IDX_INT_MASK, `IMAC_IDX_RATE: acc_ok = (paddr[1:0] == 2'h0);
            default: acc_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Source range per rate
    // ----------------------------------------------------------------
    always_comb
    begin
        case (s_q.rate)
            IMAC_RATE_8M: max_st = `IMAC_MAX_ST_8M;
            IMAC_RATE_SUB: max_st = `IMAC_MAX_ST_SUB;
            default: max_st = `IMAC_MAX_ST_2M;
        endcase
        if (s_q.rate == IMAC_RATE_8M)
        begin
            src_ch = cur_word[`IMAC_CW_SCH_HI:`IMAC_CW_SCH_LO];
        end
        else
        begin
            // Sub-rate mode uses 32 channels here; the wider form needs mode detail not held by this block.
            src_ch = {2'h0, cur_word[4:0]};
        end
        range_err = !cur_word[`IMAC_CW_MSG] && (src_st > max_st);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        rise_rd = 1'b0;
        rise_wr = 1'b0;
        hw_done = 1'b0;

        // APB: one wait cycle, so every answer comes from a flop.
        s_d.pready = 1'b0;
        if (psel && penable && !s_q.pready)
        begin
            s_d.pready = 1'b1;
            s_d.pslverr = !acc_ok;
            s_d.prdata = 32'h0000_0000;
            if (acc_ok && !pwrite)
            begin
                case (reg_idx)
                    `IMAC_IDX_ADDR_BUF: s_d.prdata = {16'h0000, s_q.abuf};
                    `IMAC_IDX_WR_DATA: s_d.prdata = {16'h0000, s_q.wdata};
                    `IMAC_IDX_RD_DATA: s_d.prdata = {16'h0000, s_q.rdata};
                    `IMAC_IDX_INT_STAT: s_d.prdata = {30'h0, s_q.int_stat};
                    `IMAC_IDX_INT_MASK: s_d.prdata = {30'h0, s_q.int_mask};
                    `IMAC_IDX_RATE: s_d.prdata = {30'h0, s_q.rate};
                    default: s_d.prdata = 32'h0000_0000;
                endcase
            end
        end

        // Memory transfer completes one cycle after it starts.
        if (s_q.xst == IMAC_X_BUSY)
        begin
            if (s_q.abuf[`IMAC_AB_ST_HI:`IMAC_AB_ST_LO] == 5'h00)
            begin
                if (s_q.xrd)
                begin
                    s_d.rdata = s_q.cmem[s_q.abuf[`IMAC_AB_CH_HI:`IMAC_AB_CH_LO]];
                end
                else
                begin
                    s_d.cmem[s_q.abuf[`IMAC_AB_CH_HI:`IMAC_AB_CH_LO]] = s_q.wdata;
                end
            end
            else if (s_q.xrd)
            begin
                s_d.rdata = 16'h0000;
            end
            s_d.abuf[`IMAC_AB_DONE] = 1'b1;
            s_d.abuf[`IMAC_AB_RSEL] = 1'b0;
            s_d.abuf[`IMAC_AB_WSEL] = 1'b0;
            s_d.xst = IMAC_X_IDLE;
            hw_done = 1'b1;
        end

        if (wr_now)
        begin
            case (reg_idx)
                `IMAC_IDX_ADDR_BUF:
                begin
                    rise_rd = pwdata[`IMAC_AB_RSEL] && !s_q.abuf[`IMAC_AB_RSEL];
                    rise_wr = pwdata[`IMAC_AB_WSEL] && !s_q.abuf[`IMAC_AB_WSEL];
                    if (s_q.xst == IMAC_X_IDLE)
                    begin
                        s_d.abuf[13:0] = pwdata[13:0];
                        // A release write drops the done flag; a new start drops it too.
                        if ((s_q.sw_sel & ~pwdata[13:12]) != 2'h0 || rise_rd || rise_wr)
                        begin
                            s_d.abuf[`IMAC_AB_DONE] = 1'b0;
                        end
                        if (rise_rd || rise_wr)
                        begin
                            s_d.xst = IMAC_X_BUSY;
                            s_d.xrd = rise_rd;
                        end
                        s_d.sw_sel = pwdata[13:12];
                    end
                end
                `IMAC_IDX_WR_DATA: s_d.wdata = pwdata[15:0];
                `IMAC_IDX_INT_STAT: s_d.int_stat = s_q.int_stat & ~pwdata[1:0];
                `IMAC_IDX_INT_MASK: s_d.int_mask = pwdata[1:0];
                `IMAC_IDX_RATE:
                begin
                    if (pwdata[1:0] != 2'h3)
                    begin
                        s_d.rate = imac_rate_t'(pwdata[1:0]);
                    end
                end
                default: s_d.int_mask = s_q.int_mask;
            endcase
        end

        // Sticky events win over a clear in the same cycle.
        if (hw_done)
        begin
            s_d.int_stat[`IMAC_INT_DONE] = 1'b1;
        end
        if (range_err)
        begin
            s_d.int_stat[`IMAC_INT_RANGE] = 1'b1;
        end
        s_d.irq = |(s_q.int_stat & s_q.int_mask);

        // Output slot pipeline: stage one addresses local memory, stage two drives.
        s_d.p1_msg = cur_word[`IMAC_CW_MSG];
        s_d.p1_byte = cur_word[7:0];
        s_d.p1_oe = cur_word[`IMAC_CW_DIR] && !range_err;
        s_d.p1_cd = cur_word[`IMAC_CW_CONST];
        s_d.lst = src_st;
        s_d.lch = src_ch;
        s_d.out_data = s_q.p1_msg ? s_q.p1_byte : local_data;
        s_d.out_oe = s_q.p1_oe;
        s_d.out_cd = s_q.p1_cd;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.abuf <= `IMAC_RST_ADDR_BUF;
            s_q.wdata <= `IMAC_RST_WR_DATA;
            s_q.int_mask <= `IMAC_RST_MASK;
            s_q.xst <= IMAC_X_IDLE;
            s_q.rate <= IMAC_RATE_2M;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign local_stream = s_q.lst;
    assign local_channel = s_q.lch;
    assign backplane_serial_line_data = s_q.out_data;
    assign backplane_serial_line_oe = s_q.out_oe;
    assign const_delay = s_q.out_cd;
    assign irq = s_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_done_after_start: assert property (s_q.xst == IMAC_X_BUSY |=> s_q.abuf[14])
        else $error("done flag not set after transfer");
    a_done_release: assert property (wr_now && reg_idx == `IMAC_IDX_ADDR_BUF && s_q.xst == IMAC_X_IDLE
        && s_q.sw_sel[1] && !pwdata[13] |=> !s_q.abuf[14])
        else $error("done flag not cleared on select release");
    a_read_start: assert property (wr_now && reg_idx == `IMAC_IDX_ADDR_BUF && s_q.xst == IMAC_X_IDLE
        && pwdata[13] && !s_q.abuf[13] |=> s_q.xst == IMAC_X_BUSY ##1 s_q.abuf[14])
        else $error("read select rise did not run a transfer");
    a_sel_selfclr: assert property ($rose(s_q.abuf[14]) |-> !s_q.abuf[13] && !s_q.abuf[12])
        else $error("select bit still set when done rose");
    a_write_store: assert property (s_q.xst == IMAC_X_BUSY && !s_q.xrd && s_q.abuf[4:0] == 5'h00
        |=> s_q.cmem[$past(s_q.abuf[11:5])] == $past(s_q.wdata))
        else $error("write transfer did not store word");
    a_read_load: assert property (s_q.xst == IMAC_X_BUSY && s_q.xrd && s_q.abuf[4:0] == 5'h00
        |=> s_q.rdata == $past(s_q.cmem[s_q.abuf[11:5]]))
        else $error("read transfer loaded wrong word");
    a_msg_byte: assert property (cur_word[12] |-> ##2 backplane_serial_line_data == $past(cur_word[7:0], 2))
        else $error("message byte not driven");
    a_oe_follow: assert property (##2 backplane_serial_line_oe == ($past(cur_word[11], 2) && !$past(range_err, 2)))
        else $error("driver enable does not follow word");
    a_delay_follow: assert property (##2 const_delay == $past(cur_word[13], 2))
        else $error("delay mode does not follow word");
    a_src_addr: assert property (##1 local_stream == $past(cur_word[10:7]))
        else $error("local stream address wrong");
    a_chan_width: assert property (s_q.rate != IMAC_RATE_8M |=> local_channel[6:5] == 2'h0)
        else $error("channel field too wide for rate");
    a_range_flag: assert property (range_err |=> s_q.int_stat[1])
        else $error("range event lost");
    a_irq_level: assert property (|(s_q.int_stat & s_q.int_mask) |=> irq)
        else $error("interrupt not raised");
    a_oe_range: assert property (range_err |-> ##2 !backplane_serial_line_oe)
        else $error("driver left on for an out of range source");

    // ----------------------------------------------------------------
    // Register side assertions, with two on the output slot pipeline
    // ----------------------------------------------------------------
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood for more than one cycle");
    a_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("access phase got no answer");
    a_unmapped_err: assert property (psel && penable && !pready && !acc_ok |=> pslverr)
        else $error("unmapped access not flagged");
    a_write_rdata: assert property (psel && penable && !pready && pwrite |=> prdata == 32'h0000_0000)
        else $error("read data not zero on a write");
    a_write_start: assert property (wr_now && reg_idx == `IMAC_IDX_ADDR_BUF && s_q.xst == IMAC_X_IDLE
        && pwdata[12] && !pwdata[13] && !s_q.abuf[12] |=> s_q.xst == IMAC_X_BUSY && !s_q.xrd)
        else $error("write select rise did not start a write");
    a_addr_fields: assert property (wr_now && reg_idx == `IMAC_IDX_ADDR_BUF && s_q.xst == IMAC_X_IDLE
        |=> s_q.abuf[11:0] == $past(pwdata[11:0]))
        else $error("channel or stream field not loaded");
    a_sel_hold: assert property (s_q.xst == IMAC_X_IDLE && !wr_now
        |=> s_q.abuf[13:12] == $past(s_q.abuf[13:12]))
        else $error("select bits moved with no write and no transfer");
    a_wdata_load: assert property (wr_now && reg_idx == `IMAC_IDX_WR_DATA
        |=> s_q.wdata == $past(pwdata[15:0]))
        else $error("write data word not loaded");
    a_one_cycle: assert property (s_q.xst == IMAC_X_BUSY |=> s_q.xst == IMAC_X_IDLE)
        else $error("transfer took more than one cycle");
    a_done_hold: assert property (s_q.abuf[14] && !wr_now |=> s_q.abuf[14])
        else $error("done flag dropped without a release");
    a_stream_refuse: assert property (s_q.xst == IMAC_X_BUSY && !s_q.xrd && s_q.abuf[4:0] != 5'h00
        |=> s_q.cmem == $past(s_q.cmem))
        else $error("write to another stream changed the memory");
    a_read_other: assert property (s_q.xst == IMAC_X_BUSY && s_q.xrd && s_q.abuf[4:0] != 5'h00
        |=> s_q.rdata == 16'h0000)
        else $error("read of another stream not zero");
    a_rdata_hold: assert property (!(s_q.xst == IMAC_X_BUSY && s_q.xrd)
        |=> s_q.rdata == $past(s_q.rdata))
        else $error("read data changed with no read transfer");
    a_cmem_hold: assert property (!(s_q.xst == IMAC_X_BUSY && !s_q.xrd)
        |=> s_q.cmem == $past(s_q.cmem))
        else $error("memory changed with no write transfer");
    a_local_byte: assert property (!cur_word[12] |-> ##2 backplane_serial_line_data == $past(local_data))
        else $error("switched byte not driven");
    a_chan_full: assert property (s_q.rate == IMAC_RATE_8M |=> local_channel == $past(cur_word[6:0]))
        else $error("channel field cut at the fast rate");
    a_rate_ignore: assert property (wr_now && reg_idx == `IMAC_IDX_RATE && pwdata[1:0] == 2'h3
        |=> s_q.rate == $past(s_q.rate))
        else $error("unused rate code was taken");
    a_mask_load: assert property (wr_now && reg_idx == `IMAC_IDX_INT_MASK
        |=> s_q.int_mask == $past(pwdata[1:0]))
        else $error("mask not loaded");
    a_stat_clear: assert property (wr_now && reg_idx == `IMAC_IDX_INT_STAT && pwdata[0] && !hw_done
        |=> !s_q.int_stat[0])
        else $error("done event not cleared by a one");
    a_stat_sticky: assert property (s_q.int_stat[0] && !(wr_now && reg_idx == `IMAC_IDX_INT_STAT && pwdata[0])
        |=> s_q.int_stat[0])
        else $error("done event dropped on its own");
    a_irq_low: assert property (!(|(s_q.int_stat & s_q.int_mask)) |=> !irq)
        else $error("interrupt high with nothing pending");

    c_read_xfer: cover property (s_q.xst == IMAC_X_BUSY && s_q.xrd ##1 s_q.abuf[14]);
    c_write_xfer: cover property (s_q.xst == IMAC_X_BUSY && !s_q.xrd ##1 s_q.abuf[14]);
    c_msg_slot: cover property (cur_word[12] && cur_word[11]);
    c_irq_rise: cover property ($rose(irq));
    c_range_slot: cover property (range_err ##1 s_q.int_stat[1]);

endmodule : imac_top

/* File: bench/imac_ldm_model.sv */
// Local data memory model that answers a source address within the same cycle.
`timescale 1ns/10ps
module imac_ldm_model
(
    input wire logic [3:0] local_stream, // Source stream.
    input wire logic [6:0] local_channel, // Source channel.
    output logic [7:0] local_data // Byte held at that place.
);
    // Contents are a pattern of the address, so a misrouted field shows up in the byte.
    // The address already leaves the block from a flop, so the answer must come in that same cycle.
    assign local_data = {local_stream, local_channel[3:0]} ^ {local_channel[6:4], 5'h00};
endmodule : imac_ldm_model

/* File: bench/test_indirect_memory_access_and_conn_memory.sv */
// Self-checking bench for the indirect memory access block.
`timescale 1ns/10ps
module test_indirect_memory_access_and_conn_memory;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, boe, cdly, irq, err;
    logic [7:0] paddr, ldat, bdat;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] slot_index, lch, cm;
    logic [3:0] lst, lim;
    logic [15:0] w;
    int errors, tests_run, cycles;

    imac_top u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slot_index(slot_index), .local_data(ldat), .local_stream(lst), .local_channel(lch),
        .backplane_serial_line_data(bdat), .backplane_serial_line_oe(boe), .const_delay(cdly), .irq(irq));
    imac_ldm_model u_ldm(.local_stream(lst), .local_channel(lch), .local_data(ldat));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk(32'(n < 50), 32'h1, "bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, 8'h30, 32'h0);
            n++;
        end while (rd[14] !== 1'b1 && n < 20);
    endtask : wait_done

    task automatic put_word(input logic [6:0] ch, input logic [15:0] d);
        apb(1'b1, 8'h34, {16'h0, d});
        apb(1'b1, 8'h30, 32'h1000 | 32'({ch, 5'h00}));
        wait_done();
        chk(rd, 32'h4000 | 32'({ch, 5'h00}), "write done");
        apb(1'b1, 8'h30, 32'({ch, 5'h00}));
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'({ch, 5'h00}), "done release");
    endtask : put_word

    task automatic get_word(input logic [6:0] ch, input logic [4:0] st, input logic [15:0] d);
        apb(1'b1, 8'h30, 32'h2000 | 32'({ch, st}));
        wait_done();
        chk(rd, 32'h4000 | 32'({ch, st}), "read done");
        apb(1'b0, 8'h38, 32'h0);
        chk(rd, {16'h0, d}, "read data");
        apb(1'b1, 8'h30, 32'({ch, st}));
    endtask : get_word

    task automatic look(input logic [7:0] d, input logic o, input logic c);
        repeat (3) @(posedge pclk);
        chk({24'h0, bdat}, {24'h0, d}, "line data");
        chk({31'h0, boe}, {31'h0, o}, "driver enable");
        chk({31'h0, cdly}, {31'h0, c}, "delay mode");
    endtask : look

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, slot_index} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0, "address buffer reset");
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0, "write data reset");
        apb(1'b0, 8'h44, 32'h0);
        chk(rd, 32'h0, "mask reset");
        apb(1'b0, 8'hfc, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");
        // Message word: constant delay, driver on, low byte on the line; bits 15,14 zero.
        put_word(7'h05, 16'h3a5c);
        slot_index <= 7'h05;
        look(8'h5c, 1'b1, 1'b1);
        get_word(7'h05, 5'h00, 16'h3a5c);
        apb(1'b1, 8'h34, 32'hbeef);
        apb(1'b1, 8'h30, 32'h10a1);
        wait_done();
        apb(1'b1, 8'h30, 32'h00a1);
        get_word(7'h05, 5'h00, 16'h3a5c);
        get_word(7'h05, 5'h01, 16'h0000);
        $display("test transfers done");
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h1, "done event");
        chk({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, 8'h44, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        apb(1'b1, 8'h40, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        apb(1'b1, 8'h44, 32'h2);
        $display("test interrupt done");
        for (int r = 0; r < 3; r++)
        begin
            lim = (r == 0) ? 4'hf : (r == 1) ? 4'h3 : 4'hc;
            cm = (r == 1) ? 7'h65 : 7'h05;
            apb(1'b1, 8'h48, 32'(r));
            w = 16'h0800 | 16'({lim, 7'h65});
            put_word(7'h09, w);
            slot_index <= 7'h09;
            look({lim, cm[3:0]} ^ {cm[6:4], 5'h00}, 1'b1, 1'b0);
            chk({28'h0, lst}, {28'h0, lim}, "source stream");
            chk({25'h0, lch}, {25'h0, cm}, "source channel");
            if (lim != 4'hf)
            begin
                put_word(7'h09, w + 16'h0080);
                look({lim + 4'h1, cm[3:0]} ^ {cm[6:4], 5'h00}, 1'b0, 1'b0);
                chk({31'h0, irq}, 32'h1, "range irq");
                slot_index <= 7'h05;
                repeat (3) @(posedge pclk);
                apb(1'b1, 8'h40, 32'h3);
                repeat (2) @(posedge pclk);
                chk({31'h0, irq}, 32'h0, "range cleared");
            end
        end
        apb(1'b1, 8'h48, 32'h3);
        apb(1'b0, 8'h48, 32'h0);
        chk(rd, 32'h2, "rate code three ignored");
        $display("test rates done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({30'h0, irq, boe}, 32'h0, "outputs in reset");
        presetn <= 1'b1;
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0, "address buffer after reset");
        $display("test reset again done");
        report_and_stop();
    end
endmodule : test_indirect_memory_access_and_conn_memory
